// File: scrb_config_bank.v
// serial-loaded configuration register bank with shadowed fields
`timescale 1ns/1ns
`include "scrb_defs.vh"
module scrb_config_bank #(
  parameter WORD_BITS = `SCRB_WORD_BITS
) (
  input wire clk,
  input wire reset,
  input wire serialClock,
  input wire serialData,
  input wire loadStrobe,
  output reg [WORD_BITS-1:0] integerFractionWord,
  output reg [WORD_BITS-1:0] prescalerPhaseModulus,
  output reg [WORD_BITS-1:0] referenceLoopControl,
  output reg [WORD_BITS-1:0] clockDividerSlipControl,
  output reg [WORD_BITS-1:0] outputBandSelectControl,
  output reg [WORD_BITS-1:0] lockPinSetup,
  output reg [15:0] integerValue,
  output reg [11:0] fractionNumerator,
  output reg loadPulse
);
  // pins are asynchronous to clk: two flops before any use
  reg [2:0] clkSync1;
  reg [2:0] clkSync2;
  reg clkPrev;
  reg strobePrev;
  reg [WORD_BITS-1:0] shiftWord;
  // shadow copies of the written words; active copies are the outputs
  reg [WORD_BITS-1:0] shadow1;
  reg [WORD_BITS-1:0] shadow2;
  reg [WORD_BITS-1:0] shadow4;
  wire sclkRise;
  wire strobeRise;
  wire [2:0] sel;
  wire dbbOn;
  wire [WORD_BITS-1:0] r1Mask;
  wire [WORD_BITS-1:0] r2Mask;
  wire [WORD_BITS-1:0] r4Mask;
  assign sclkRise = clkSync2[0] & ~clkPrev;
  assign strobeRise = clkSync2[2] & ~strobePrev;
  assign sel = shiftWord[`SCRB_SEL_HI:`SCRB_SEL_LO];
  // enable comes from the active register 2 copy
  assign dbbOn = referenceLoopControl[`SCRB_R2_DBB_EN];
  assign r1Mask = `SCRB_R1_DB_MASK;
  assign r2Mask = `SCRB_R2_DB_MASK;
  assign r4Mask = dbbOn ? `SCRB_R4_DBB_MASK : `SCRB_RESET_WORD;
  always @(posedge clk) begin
    if (reset) begin
      clkSync1 <= 3'h0;
      clkSync2 <= 3'h0;
      clkPrev <= 1'b0;
      strobePrev <= 1'b0;
      shiftWord <= `SCRB_RESET_WORD;
    end else begin
      clkSync1 <= {loadStrobe, serialData, serialClock};
      clkSync2 <= clkSync1;
      clkPrev <= clkSync2[0];
      strobePrev <= clkSync2[2];
      // data sampled with the same delay as the clock, so setup is kept
      if (sclkRise) begin
        shiftWord <= {shiftWord[WORD_BITS-2:0], clkSync2[1]};
      end
    end
  end
  // next values of every latch, decoded from one strobe edge
  reg [WORD_BITS-1:0] next_integerFractionWord;
  reg [WORD_BITS-1:0] next_prescalerPhaseModulus;
  reg [WORD_BITS-1:0] next_referenceLoopControl;
  reg [WORD_BITS-1:0] next_clockDividerSlipControl;
  reg [WORD_BITS-1:0] next_outputBandSelectControl;
  reg [WORD_BITS-1:0] next_lockPinSetup;
  reg [WORD_BITS-1:0] next_shadow1;
  reg [WORD_BITS-1:0] next_shadow2;
  reg [WORD_BITS-1:0] next_shadow4;
  reg [15:0] next_integerValue;
  reg [11:0] next_fractionNumerator;
  reg next_loadPulse;
  always @* begin
    next_integerFractionWord = integerFractionWord;
    next_prescalerPhaseModulus = prescalerPhaseModulus;
    next_referenceLoopControl = referenceLoopControl;
    next_clockDividerSlipControl = clockDividerSlipControl;
    next_outputBandSelectControl = outputBandSelectControl;
    next_lockPinSetup = lockPinSetup;
    next_shadow1 = shadow1;
    next_shadow2 = shadow2;
    next_shadow4 = shadow4;
    next_integerValue = integerValue;
    next_fractionNumerator = fractionNumerator;
    next_loadPulse = 1'b0;
    if (strobeRise) begin
      case (sel)
        `SCRB_SEL_R0: begin
          next_loadPulse = 1'b1;
          next_integerFractionWord = shiftWord;
          next_integerValue = shiftWord[`SCRB_INT_HI:`SCRB_INT_LO];
          next_fractionNumerator = shiftWord[`SCRB_FRACTION_NUMERATOR_HI:`SCRB_FRACTION_NUMERATOR_LO];
          // shadowed fields go live now
          next_prescalerPhaseModulus = shadow1;
          next_referenceLoopControl = shadow2;
          next_outputBandSelectControl = shadow4;
        end
        `SCRB_SEL_R1: begin
          next_loadPulse = 1'b1;
          next_shadow1 = shiftWord;
          next_prescalerPhaseModulus = (prescalerPhaseModulus & r1Mask)
            | (shiftWord & ~r1Mask);
        end
        `SCRB_SEL_R2: begin
          next_loadPulse = 1'b1;
          next_shadow2 = shiftWord;
          next_referenceLoopControl = (referenceLoopControl & r2Mask)
            | (shiftWord & ~r2Mask);
        end
        `SCRB_SEL_R3: begin
          next_loadPulse = 1'b1;
          next_clockDividerSlipControl = shiftWord;
        end
        `SCRB_SEL_R4: begin
          next_loadPulse = 1'b1;
          next_shadow4 = shiftWord;
          // mask follows the applied bit 13, not a pending one
          next_outputBandSelectControl = (outputBandSelectControl & r4Mask)
            | (shiftWord & ~r4Mask);
        end
        `SCRB_SEL_R5: begin
          next_loadPulse = 1'b1;
          next_lockPinSetup = shiftWord;
        end
        default: begin
          // codes 110 and 111 leave every latch untouched
          next_loadPulse = 1'b0;
        end
      endcase
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      integerFractionWord <= `SCRB_RESET_WORD;
    end else begin
      integerFractionWord <= next_integerFractionWord;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      prescalerPhaseModulus <= `SCRB_RESET_WORD;
    end else begin
      prescalerPhaseModulus <= next_prescalerPhaseModulus;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      referenceLoopControl <= `SCRB_RESET_WORD;
    end else begin
      referenceLoopControl <= next_referenceLoopControl;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      clockDividerSlipControl <= `SCRB_RESET_WORD;
    end else begin
      clockDividerSlipControl <= next_clockDividerSlipControl;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      outputBandSelectControl <= `SCRB_RESET_WORD;
    end else begin
      outputBandSelectControl <= next_outputBandSelectControl;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      lockPinSetup <= `SCRB_RESET_WORD;
    end else begin
      lockPinSetup <= next_lockPinSetup;
    end
  end
  // shadows hold full words so a register 0 write applies them whole
  always @(posedge clk) begin
    if (reset) begin
      shadow1 <= `SCRB_RESET_WORD;
    end else begin
      shadow1 <= next_shadow1;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      shadow2 <= `SCRB_RESET_WORD;
    end else begin
      shadow2 <= next_shadow2;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      shadow4 <= `SCRB_RESET_WORD;
    end else begin
      shadow4 <= next_shadow4;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      integerValue <= 16'h0000;
    end else begin
      integerValue <= next_integerValue;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      fractionNumerator <= 12'h000;
    end else begin
      fractionNumerator <= next_fractionNumerator;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      loadPulse <= 1'b0;
    end else begin
      loadPulse <= next_loadPulse;
    end
  end
endmodule // scrb_config_bank

// File: scrb_defs.vh
// register layout constants for the synthesizer configuration bank
// Overview of operation
// - host sends 32 bits msb first; one bit shifts in per serial clock rise
// - load strobe rise copies shifted word into latch named by select bits
// - bits 2..0 select register; 000 to 101 name registers 0 to 5
// - register 0 holds 16-bit integer value in bits 30..15
// - register 0 holds 12-bit fraction numerator in bits 14..3
// - phase, modulus, doubler, halving, r counter, pump current wait for register 0
// - divider select shadowed until register 0 write only when reg2 bit 13 set
`ifndef SCRB_DEFS_VH
`define SCRB_DEFS_VH
`define SCRB_WORD_BITS 32
`define SCRB_SEL_HI 2
`define SCRB_SEL_LO 0
`define SCRB_SEL_R0 3'h0
`define SCRB_SEL_R1 3'h1
`define SCRB_SEL_R2 3'h2
`define SCRB_SEL_R3 3'h3
`define SCRB_SEL_R4 3'h4
`define SCRB_SEL_R5 3'h5
`define SCRB_INT_HI 30
`define SCRB_INT_LO 15
`define SCRB_FRACTION_NUMERATOR_HI 14
`define SCRB_FRACTION_NUMERATOR_LO 3
// register 1 shadowed: phase 26..15, modulus 14..3
`define SCRB_R1_DB_MASK 32'h07FFFFF8
// register 2 shadowed: doubler 25, halving 24, r counter 23..14, pump current 12..9
`define SCRB_R2_DB_MASK 32'h03FFDE00
`define SCRB_R2_DBB_EN 13
// register 4 divider select 22..20
`define SCRB_R4_DBB_MASK 32'h00700000
`define SCRB_RESET_WORD 32'h00000000
`endif

// File: scrb_config_bank_props.sv
// output assertions for the configuration bank
`timescale 1ns/1ns
module scrb_config_bank_props (
  input logic clk, reset, loadPulse,
  input logic [31:0] integerFractionWord, prescalerPhaseModulus, referenceLoopControl,
  input logic [31:0] clockDividerSlipControl, outputBandSelectControl, lockPinSetup,
  input logic [15:0] integerValue,
  input logic [11:0] fractionNumerator
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  AST_INT: assert property (integerValue == integerFractionWord[30:15])
    else $error("int");
  AST_FRACTION_NUMERATOR: assert property (fractionNumerator == integerFractionWord[14:3])
    else $error("fraction_numerator");
  AST_SEL: assert property ($changed(lockPinSetup) |-> lockPinSetup[2:0] == 3'h5)
    else $error("sel");
  AST_PULSE: assert property (loadPulse |=> !loadPulse) else $error("pulse");
  AST_CAUSE: assert property ($changed(clockDividerSlipControl) |->
    (loadPulse || $past(loadPulse)) or ##1 loadPulse) else $error("cause");
  AST_R1: assert property ($changed(prescalerPhaseModulus[31:27]) |->
    $stable(prescalerPhaseModulus[26:3])) else $error("r1");
  AST_R2: assert property ($changed(referenceLoopControl[31:26]) |->
    $stable(referenceLoopControl[25:14])) else $error("r2");
  AST_R4: assert property (referenceLoopControl[13] &&
    $changed(outputBandSelectControl[19:3]) |-> $stable(outputBandSelectControl[22:20]))
    else $error("r4");
endmodule // scrb_config_bank_props
bind scrb_config_bank scrb_config_bank_props scrb_config_bank_props_inst (.*);

// File: scrb_host_model.sv
// host model driving the serial load port
`timescale 1ns/1ns
module scrb_host_model (output reg serialClock = 1'h0, serialData = 1'h0, loadStrobe = 1'h0);
  task send(input [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      serialData = w[i];
      #200 serialClock = 1'h1;
      #200 serialClock = 1'h0;
    end
    serialData = ~w[0]; // idle line inverted so no stale bit reads as valid
    #200 loadStrobe = 1'h1;
    #400 loadStrobe = 1'h0;
  endtask
endmodule // scrb_host_model

// File: scrb_config_bank_bench.sv
// bench comparing the bank with a register model
`timescale 1ns/1ns
`include "scrb_defs.vh"
module scrb_config_bank_bench;
  reg clk = 1'h0, reset = 1'h1;
  wire serialClock, serialData, loadStrobe, loadPulse;
  wire [31:0] integerFractionWord, prescalerPhaseModulus, referenceLoopControl;
  wire [31:0] clockDividerSlipControl, outputBandSelectControl, lockPinSetup;
  wire [15:0] integerValue;
  wire [11:0] fractionNumerator;
  // bits each register may carry; reserved positions are written as zero
  reg [31:0] keep [0:7] = '{32'h7FFFFFFF, 32'h0FFFFFFF, 32'h7FFFFFFF, 32'h0005FFFF,
    32'h00FFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  wire [191:0] regs = {lockPinSetup, outputBandSelectControl, clockDividerSlipControl,
    referenceLoopControl, prescalerPhaseModulus, integerFractionWord};
  reg [31:0] act [0:5] = '{default: 0}, shd [0:5] = '{default: 0}, w, m;
  reg [15:0] lfsr = 16'h8844;
  integer failures = 0, checks = 0, cyc = 0, k, j, pulses = 0, loads = 0;
  always #25 clk = ~clk;
  always @(posedge clk) if (loadPulse === 1'b1) pulses <= pulses + 1;
  scrb_config_bank scrb_config_bank_inst (.*);
  scrb_host_model scrb_host_model_inst (.*);
  function [15:0] step(input [15:0] s); step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]}; endfunction
  task end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS"); else $display("DONE - FAIL");
    $finish;
  endtask
  // fourteen frames need about 4000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) failures++;
    if (cyc == 8000) end_of_test;
  end
  initial begin
    repeat (8) @(posedge clk);
    for (k = 0; k < 14; k = k + 1) begin
      #1 reset = 1'h0;
      lfsr = step(lfsr);
      w = {2'h1, lfsr, lfsr[15:5], 3'(56'h40761402054321 >> k * 4)};
      w = w & keep[w[2:0]];
      if (w[2:0] == 3'h0) w[14:3] = shd[1][14:3] ? w[14:3] % shd[1][14:3] : 12'h000;
      if (w[2:0] == 3'h2) w[13] = k > 5;
      if (w[2:0] == 3'h5) w = {8'h00, w[23:22], 22'h180005};
      scrb_host_model_inst.send(w);
      j = w[2:0];
      if (j < 6) loads++;
      m = j == 1 ? `SCRB_R1_DB_MASK : j == 2 ? `SCRB_R2_DB_MASK : 0;
      if (j == 4 && act[2][13]) m = `SCRB_R4_DBB_MASK;
      if (j < 6) {act[j], shd[j]} = {act[j] & m | w & ~m, w};
      if (j == 0) {act[1], act[2], act[4]} = {shd[1], shd[2], shd[4]};
      repeat (8) @(posedge clk);
      for (j = 0; j < 6; j++) if (regs[j * 32 +: 32] !== act[j]) begin
        failures++;
        $display("[FAIL] %0t %h %h", $time, regs[j * 32 +: 32], act[j]);
      end
      if ({integerValue, fractionNumerator} !== {act[0][30:15], act[0][14:3]}) begin
        failures++;
        $display("[FAIL] %0t %h %h", $time, {integerValue, fractionNumerator},
          {act[0][30:15], act[0][14:3]});
      end
      if (pulses !== loads) begin
        failures++;
        $display("[FAIL] %0t %h %h", $time, pulses, loads);
      end
      checks += 8;
    end
    end_of_test;
  end
endmodule // scrb_config_bank_bench
